/* File: rtl/rps_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - PWM goes to PFM only after light-load condition lasts 32 switching cycles
// R2 - In PFM, below low threshold, high side on until high threshold or peak
// R3 - After high side, low side on until zero current, repeat while below high
// R4 - At high threshold, low side zeroes current, then both off and sleep
// R5 - Output below the low2 threshold returns the converter to PWM
// R6 - Mode is automatic by default; force bit set holds PWM
// R7 - Each converter has an enable bit in its control register
// R8 - Finishing power-up enables both converters and restores default voltages
// R9 - Shut-down converter keeps low side on, high side and control off
// R10 - Soft start only on enable rising while supply is good
// R11 - Soft-start current limit steps 180/300/720 and 161/300/536 mA
// R12 - Host keeps converters off during power-up and low supply
// R13 - Every regulator has its own enable pin
// R14 - Undriven enables and trigger read low, regulators stay off
// R15 - Trigger rising edge starts the timed power-on sequence
// R16 - Trigger falling edge starts the timed power-off sequence
// R17 - Trigger is deglitched for 1 ms before an edge counts
// R18 - While trigger is high, enable pins have no effect
// R19 - Regulator on = enable bit AND (own pin OR trigger high)
// R20 - Power-on delays default 1.5, 2, 3 and 6 ms
// R21 - Power-on delays programmable to 1, 1.5, 2, 3, 6 or 11 ms
// R22 - Power-off delays default 1.5, 2, 3 and 6 ms
// R23 - Power-off delays factory-set from 0, 0.5, 1, 2, 5, 10 ms; the default OFF_DLY gives 1.5, 2, 3 and 6 ms
// R24 - A new trigger edge aborts the running sequence and restarts timing
// R25 - Sequence delays counted on a 0.5 ms internal time base
module rps_sequencer #(
  parameter int TICK_CYCLES = rps_pkg::TICK_CYCLES,
  parameter int DEGLITCH_CYCLES = rps_pkg::DEGLITCH_CYCLES,
  parameter logic [19:0] OFF_DLY = rps_pkg::OFF_DLY_RST
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic seq_trigger_pin,
  input wire logic buck_one_enable_pin,
  input wire logic buck_two_enable_pin,
  input wire logic linear_one_enable_pin,
  input wire logic linear_two_enable_pin,
  input wire logic supply_ok,
  // Converter comparators
  input wire rps_pkg::rps_sense_s [1:0] sense,
  // Regulator controls
  output rps_pkg::rps_gate_s [1:0] gate,
  output logic [1:0][9:0] ilim_ma,
  output logic [3:0] reg_on,
  output logic [3:0][4:0] vsel
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int DW = $clog2(DEGLITCH_CYCLES + 1);

  logic [5:0] pin_m, pin_s;
  logic [13:0] sns_m, sns_s;
  rps_pkg::rps_sense_s [1:0] sn;
  logic trig_f, trig_rise, trig_fall;
  logic [DW-1:0] dg_cnt;
  rps_pkg::rps_seq_e seq_state;
  logic [TW-1:0] tick_cnt;
  logic [4:0] elapsed;
  logic [3:0] seq_on, en_bit;
  logic [1:0] fpwm;
  logic [11:0] on_dly;
  logic [3:0] next_reg_on;
  logic [3:0] pin_en;
  logic [3:0][4:0] on_half, off_half;
  logic sw_en;
  logic [3:0] sw_cnt;
  logic acc_go, wr_go;
  logic rd_hit;
  logic [31:0] rd_word;

  // Pin synchronisers; reset low so an open pin keeps everything off
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_m <= '0; // R14
      pin_s <= '0;
      sns_m <= '0;
      sns_s <= '0;
    end else begin
      pin_m <= {seq_trigger_pin, linear_two_enable_pin, linear_one_enable_pin,
                buck_two_enable_pin, buck_one_enable_pin, supply_ok};
      pin_s <= pin_m;
      sns_m <= sense;
      sns_s <= sns_m;
    end
  end
  assign sn = sns_s;
  assign pin_en = pin_s[4:1]; // R13

  // Trigger deglitch
  always_ff @(posedge clock) begin
    if (rst) begin
      trig_f <= 1'b0;
      dg_cnt <= '0;
      trig_rise <= 1'b0;
      trig_fall <= 1'b0;
    end else begin
      trig_rise <= 1'b0;
      trig_fall <= 1'b0;
      if (pin_s[5] == trig_f) begin
        dg_cnt <= '0;
      end else if (dg_cnt == DW'(DEGLITCH_CYCLES - 1)) begin
        dg_cnt <= '0; // R17
        trig_f <= pin_s[5];
        trig_rise <= pin_s[5]; // R15
        trig_fall <= ~pin_s[5]; // R16
      end else begin
        dg_cnt <= dg_cnt + 1'b1;
      end
    end
  end

  // Sequence timing on the half-millisecond time base
  always_ff @(posedge clock) begin
    if (rst) begin
      seq_state <= rps_pkg::SQ_STANDBY;
      tick_cnt <= '0;
      elapsed <= '0;
    end else if (trig_rise || trig_fall) begin
      seq_state <= trig_rise ? rps_pkg::SQ_UP : rps_pkg::SQ_DOWN; // R24
      tick_cnt <= '0;
      elapsed <= '0;
    end else begin
      case (seq_state)
        rps_pkg::SQ_UP, rps_pkg::SQ_DOWN: begin
          if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0; // R25
            if (elapsed != 5'h1f) begin
              elapsed <= elapsed + 1'b1;
            end
          end else begin
            tick_cnt <= tick_cnt + 1'b1;
          end
          if (seq_state == rps_pkg::SQ_UP && seq_on == 4'hf) begin
            seq_state <= rps_pkg::SQ_ACTIVE;
          end else if (seq_state == rps_pkg::SQ_DOWN && seq_on == 4'h0) begin
            seq_state <= rps_pkg::SQ_STANDBY;
          end
        end
        default: tick_cnt <= '0;
      endcase
    end
  end

  for (genvar k = 0; k < 4; k++) begin : g_seq
    assign on_half[k] = rps_pkg::rps_on_half(on_dly[3*k +: 3]); // R21
    assign off_half[k] = OFF_DLY[5*k +: 5]; // R23
    always_ff @(posedge clock) begin
      if (rst) begin
        seq_on[k] <= 1'b0;
      end else if (seq_state == rps_pkg::SQ_UP && !trig_rise && !trig_fall
                   && elapsed >= on_half[k]) begin
        seq_on[k] <= 1'b1; // R20
      end else if (seq_state == rps_pkg::SQ_DOWN && !trig_rise && !trig_fall
                   && elapsed >= off_half[k]) begin
        seq_on[k] <= 1'b0; // R22
      end
    end
    // Pins are masked while the trigger is high
    assign next_reg_on[k] = en_bit[k] & pin_s[0]
                            & (seq_on[k] | (pin_en[k] & ~trig_f)); // R19 R18
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_on <= '0;
    end else begin
      reg_on <= next_reg_on;
    end
  end

  // APB: one wait state, write lands at the completing edge
  assign acc_go = psel & penable & ~pready;
  assign wr_go = psel & penable & pready & pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    if (paddr == rps_pkg::OFS_FIRST_CONVERTER) begin
      rd_word = {19'h0, vsel[0], 6'h0, fpwm[0], en_bit[0]};
    end else if (paddr == rps_pkg::OFS_SECOND_CONVERTER) begin
      rd_word = {19'h0, vsel[1], 6'h0, fpwm[1], en_bit[1]};
    end else if (paddr == rps_pkg::OFS_LIN1) begin
      rd_word = {19'h0, vsel[2], 7'h0, en_bit[2]};
    end else if (paddr == rps_pkg::OFS_LIN2) begin
      rd_word = {19'h0, vsel[3], 7'h0, en_bit[3]};
    end else if (paddr == rps_pkg::OFS_ON_DLY) begin
      rd_word = {20'h0, on_dly};
    end else if (paddr == rps_pkg::OFS_OFF_DLY) begin
      rd_word = {12'h0, OFF_DLY};
    end else if (paddr == rps_pkg::OFS_STATUS) begin
      rd_word = {18'h0, pin_s[0], gate[1].pfm, gate[0].pfm, trig_f,
                 2'(seq_state), seq_on, reg_on};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_go;
      pslverr <= acc_go & ~rd_hit;
      prdata <= (acc_go && !pwrite) ? rd_word : '0;
    end
  end

  // Control registers; completing power-up restores converter enables and default voltages
  always_ff @(posedge clock) begin
    if (rst) begin
      en_bit <= 4'hf;
      fpwm <= '0; // R6
      on_dly <= rps_pkg::ON_DLY_RST;
      vsel <= {rps_pkg::VSEL_RST_L2, rps_pkg::VSEL_RST_L1,
               rps_pkg::VSEL_RST_B2, rps_pkg::VSEL_RST_B1};
    end else if (seq_state == rps_pkg::SQ_UP && seq_on == 4'hf && !trig_rise
                 && !trig_fall) begin
      en_bit[1:0] <= 2'b11; // R8
      vsel[0] <= rps_pkg::VSEL_RST_B1;
      vsel[1] <= rps_pkg::VSEL_RST_B2;
    end else if (wr_go) begin
      if (paddr == rps_pkg::OFS_FIRST_CONVERTER) begin
        en_bit[0] <= pwdata[rps_pkg::EN_BIT]; // R7
        fpwm[0] <= pwdata[rps_pkg::FPWM_BIT];
        vsel[0] <= pwdata[rps_pkg::VSEL_LSB +: 5];
      end else if (paddr == rps_pkg::OFS_SECOND_CONVERTER) begin
        en_bit[1] <= pwdata[rps_pkg::EN_BIT]; // R7
        fpwm[1] <= pwdata[rps_pkg::FPWM_BIT];
        vsel[1] <= pwdata[rps_pkg::VSEL_LSB +: 5];
      end else if (paddr == rps_pkg::OFS_LIN1) begin
        en_bit[2] <= pwdata[rps_pkg::EN_BIT];
        vsel[2] <= pwdata[rps_pkg::VSEL_LSB +: 5];
      end else if (paddr == rps_pkg::OFS_LIN2) begin
        en_bit[3] <= pwdata[rps_pkg::EN_BIT];
        vsel[3] <= pwdata[rps_pkg::VSEL_LSB +: 5];
      end else if (paddr == rps_pkg::OFS_ON_DLY) begin
        on_dly <= pwdata[11:0]; // R21
      end
    end
  end

  // Switching-clock enable
  always_ff @(posedge clock) begin
    if (rst) begin
      sw_cnt <= '0;
      sw_en <= 1'b0;
    end else begin
      sw_en <= (sw_cnt == 4'(rps_pkg::SW_CYCLES - 1));
      sw_cnt <= (sw_cnt == 4'(rps_pkg::SW_CYCLES - 1)) ? 4'h0 : sw_cnt + 1'b1;
    end
  end

  // Converter control
  rps_pkg::rps_cv_e cv_state [2];
  rps_pkg::rps_cv_e next_cv [2];
  logic [5:0] persist [2];
  logic [1:0] ss_step [2];
  logic [7:0] ss_cnt [2];

  for (genvar i = 0; i < 2; i++) begin : g_cv
    logic light;
    logic ss_done;
    assign light = sn[i].dcm | sn[i].peak_low;
    assign ss_done = sw_en && ss_step[i] == 2'h2
                     && ss_cnt[i] == 8'(rps_pkg::SS_STEP_SW - 1);

    always_comb begin
      next_cv[i] = cv_state[i];
      if (!reg_on[i]) begin
        next_cv[i] = rps_pkg::CV_OFF; // R9
      end else begin
        case (cv_state[i])
          rps_pkg::CV_OFF: next_cv[i] = rps_pkg::CV_SOFT; // R10
          rps_pkg::CV_SOFT: if (ss_done) next_cv[i] = rps_pkg::CV_PWM;
          rps_pkg::CV_PWM: begin
            if (!fpwm[i] && sw_en && light
                && persist[i] == 6'(rps_pkg::PFM_PERSIST - 1)) begin
              next_cv[i] = rps_pkg::CV_SLEEP; // R1
            end
          end
          rps_pkg::CV_SLEEP: begin
            if (fpwm[i] || sn[i].below_low2) next_cv[i] = rps_pkg::CV_PWM; // R5 R6
            else if (sn[i].below_low) next_cv[i] = rps_pkg::CV_HS; // R2
          end
          rps_pkg::CV_HS: begin
            if (fpwm[i] || sn[i].below_low2) next_cv[i] = rps_pkg::CV_PWM; // R5 R6
            else if (sn[i].above_high || sn[i].peak_pfm) next_cv[i] = rps_pkg::CV_LS; // R2
          end
          rps_pkg::CV_LS: begin
            if (fpwm[i] || sn[i].below_low2) begin
              next_cv[i] = rps_pkg::CV_PWM; // R5 R6
            end else if (sn[i].zero_cur) begin
              next_cv[i] = sn[i].above_high ? rps_pkg::CV_SLEEP : rps_pkg::CV_HS; // R3 R4
            end
          end
          default: next_cv[i] = rps_pkg::CV_OFF;
        endcase
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        cv_state[i] <= rps_pkg::CV_OFF;
        gate[i] <= rps_pkg::rps_decode(rps_pkg::CV_OFF);
      end else begin
        cv_state[i] <= next_cv[i];
        gate[i] <= rps_pkg::rps_decode(next_cv[i]); // R9
      end
    end

    // Light-load persistence, counted in switching cycles
    always_ff @(posedge clock) begin
      if (rst || cv_state[i] != rps_pkg::CV_PWM || !light) begin
        persist[i] <= '0;
      end else if (sw_en && persist[i] != 6'(rps_pkg::PFM_PERSIST - 1)) begin
        persist[i] <= persist[i] + 1'b1; // R1
      end
    end

    // Soft-start current-limit steps
    always_ff @(posedge clock) begin
      if (rst || next_cv[i] != rps_pkg::CV_SOFT) begin
        ss_step[i] <= '0;
        ss_cnt[i] <= '0;
      end else if (sw_en) begin
        ss_cnt[i] <= ss_cnt[i] + 1'b1;
        if (ss_cnt[i] == 8'(rps_pkg::SS_STEP_SW - 1) && ss_step[i] != 2'h2) begin
          ss_step[i] <= ss_step[i] + 1'b1; // R11
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ilim_ma <= '0;
    end else begin
      ilim_ma[0] <= next_cv[0] != rps_pkg::CV_SOFT ? 10'h000 :
                    ss_step[0] == 2'h0 ? rps_pkg::SS_B1_MA0 :
                    ss_step[0] == 2'h1 ? rps_pkg::SS_B1_MA1 : rps_pkg::SS_B1_MA2; // R11
      ilim_ma[1] <= next_cv[1] != rps_pkg::CV_SOFT ? 10'h000 :
                    ss_step[1] == 2'h0 ? rps_pkg::SS_B2_MA0 :
                    ss_step[1] == 2'h1 ? rps_pkg::SS_B2_MA1 : rps_pkg::SS_B2_MA2; // R11
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_pfm_entry_count: assert property ((cv_state[0] == rps_pkg::CV_PWM
    ##1 cv_state[0] == rps_pkg::CV_SLEEP) |-> $past(persist[0]) == 6'd31) // R1
    else $error("PFM entered before 32 light cycles");
  a_hs_hold_on: assert property ((cv_state[0] == rps_pkg::CV_HS && reg_on[0]
    && !fpwm[0] && !sn[0].below_low2 && !sn[0].above_high && !sn[0].peak_pfm)
    |=> gate[0].hs) // R2
    else $error("High side released early");
  a_hs_then_ls: assert property (cv_state[1] == rps_pkg::CV_HS |=>
    cv_state[1] inside {rps_pkg::CV_HS, rps_pkg::CV_LS, rps_pkg::CV_PWM,
    rps_pkg::CV_OFF}) // R3
    else $error("High side not followed by low side");
  a_sleep_at_high: assert property ((cv_state[0] == rps_pkg::CV_LS && reg_on[0]
    && !fpwm[0] && !sn[0].below_low2 && sn[0].zero_cur && sn[0].above_high)
    |=> gate[0].pfm && !gate[0].hs && !gate[0].ls) // R4
    else $error("No sleep after high threshold");
  a_low2_to_pwm: assert property ((cv_state[1] inside {rps_pkg::CV_SLEEP,
    rps_pkg::CV_HS, rps_pkg::CV_LS} && reg_on[1] && sn[1].below_low2)
    |=> gate[1].pwm_run && !gate[1].pfm) // R5
    else $error("Low2 did not restore PWM");
  a_force_pwm_hold: assert property ((fpwm[0] && reg_on[0]
    && cv_state[0] == rps_pkg::CV_PWM) |=> cv_state[0] == rps_pkg::CV_PWM) // R6
    else $error("Forced PWM left");
  a_shutdown_discharge: assert property (!$past(reg_on[1]) |-> gate[1].ls
    && !gate[1].hs && !gate[1].pwm_run) // R9
    else $error("Shutdown not discharging");
  a_soft_start_gate: assert property ((cv_state[0] == rps_pkg::CV_SOFT
    && $past(cv_state[0]) == rps_pkg::CV_OFF) |-> ilim_ma[0] == rps_pkg::SS_B1_MA0
    && $past(pin_s[0], 2)) // R10
    else $error("Soft start without good supply");
  a_trig_deglitch: assert property ($rose(trig_f) |->
    $past(dg_cnt) == DW'(DEGLITCH_CYCLES - 1)) // R17
    else $error("Trigger edge taken before filter time");
  a_regulator_and: assert property (reg_on[2] |-> $past(en_bit[2])
    && $past(seq_on[2] || (pin_en[2] && !trig_f))) // R19
    else $error("Regulator on without enable term");
  a_pins_ignored: assert property (($past(trig_f) && trig_f
    && $past(seq_state) == rps_pkg::SQ_ACTIVE && seq_state == rps_pkg::SQ_ACTIVE
    && $stable(en_bit) && $stable(pin_s[0])) |=> $stable(reg_on)) // R18
    else $error("Enable pin acted while trigger high");
  a_on_delay: assert property ((seq_state == rps_pkg::SQ_UP && !trig_rise
    && !trig_fall && elapsed >= on_half[1]) |=> seq_on[1]) // R20
    else $error("Power-on delay missed");
  a_off_delay: assert property ((seq_state == rps_pkg::SQ_DOWN && !trig_rise
    && !trig_fall && elapsed < off_half[3]) |=> $past(seq_on[3]) == seq_on[3]
    || !seq_on[3] == 1'b0) // R22
    else $error("Power-off before delay");
  a_seq_restart: assert property (trig_rise |=> seq_state == rps_pkg::SQ_UP
    && elapsed == 5'h00 && tick_cnt == '0) // R24
    else $error("Sequence not restarted");

  c_pfm_sleep: cover property (cv_state[0] == rps_pkg::CV_LS
    ##1 cv_state[0] == rps_pkg::CV_SLEEP);
  c_seq_active: cover property (seq_state == rps_pkg::SQ_UP
    ##1 seq_state == rps_pkg::SQ_ACTIVE);
  c_soft_done: cover property (cv_state[1] == rps_pkg::CV_SOFT
    ##1 cv_state[1] == rps_pkg::CV_PWM);
  c_seq_abort: cover property (seq_state == rps_pkg::SQ_UP && trig_fall);
endmodule
`default_nettype wire

/* File: rtl/rps_pkg.sv */
package rps_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int TICK_US = 500;
  localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
  localparam int DEGLITCH_US = 1000;
  localparam int DEGLITCH_CYCLES = DEGLITCH_US * (CLK_HZ / 1_000_000);
  localparam int SW_PERIOD_NS = 476;
  localparam int SW_CYCLES = SW_PERIOD_NS / CLK_NS;
  localparam int PFM_PERSIST = 32;
  localparam int SS_STEP_SW = 256;
  // Register byte offsets
  localparam logic [7:0] OFS_FIRST_CONVERTER = 8'h00;
  localparam logic [7:0] OFS_SECOND_CONVERTER = 8'h04;
  localparam logic [7:0] OFS_LIN1 = 8'h08;
  localparam logic [7:0] OFS_LIN2 = 8'h0c;
  localparam logic [7:0] OFS_ON_DLY = 8'h10;
  localparam logic [7:0] OFS_OFF_DLY = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Control register fields
  localparam int EN_BIT = 0;
  localparam int FPWM_BIT = 1;
  localparam int VSEL_LSB = 8;
  localparam logic [4:0] VSEL_RST_B1 = 5'h08;
  localparam logic [4:0] VSEL_RST_B2 = 5'h10;
  localparam logic [4:0] VSEL_RST_L1 = 5'h08;
  localparam logic [4:0] VSEL_RST_L2 = 5'h10;
  // On-delay codes: 0..5 = 1, 1.5, 2, 3, 6, 11 ms; three bits per regulator
  localparam logic [11:0] ON_DLY_RST = 12'h8d1;
  // Off delays in half-millisecond ticks
  localparam logic [19:0] OFF_DLY_RST = 20'h61883;
  // Soft-start current limit steps in mA
  localparam logic [9:0] SS_B1_MA0 = 10'h0b4;
  localparam logic [9:0] SS_B1_MA1 = 10'h12c;
  localparam logic [9:0] SS_B1_MA2 = 10'h2d0;
  localparam logic [9:0] SS_B2_MA0 = 10'h0a1;
  localparam logic [9:0] SS_B2_MA1 = 10'h12c;
  localparam logic [9:0] SS_B2_MA2 = 10'h218;

  typedef enum logic [1:0] {SQ_STANDBY, SQ_UP, SQ_ACTIVE, SQ_DOWN} rps_seq_e;
  typedef enum logic [2:0] {CV_OFF, CV_SOFT, CV_PWM, CV_SLEEP, CV_HS, CV_LS} rps_cv_e;

  // Converter comparators, from the analog side
  typedef struct packed {
    logic dcm;
    logic peak_low;
    logic below_low;
    logic above_high;
    logic below_low2;
    logic peak_pfm;
    logic zero_cur;
  } rps_sense_s;

  // Converter power-stage commands
  typedef struct packed {
    logic hs;
    logic ls;
    logic pwm_run;
    logic pfm;
  } rps_gate_s;

  function automatic logic [4:0] rps_on_half(input logic [2:0] code);
    case (code)
      3'h0: rps_on_half = 5'h02;
      3'h1: rps_on_half = 5'h03;
      3'h2: rps_on_half = 5'h04;
      3'h3: rps_on_half = 5'h06;
      3'h4: rps_on_half = 5'h0c;
      default: rps_on_half = 5'h16;
    endcase
  endfunction

  function automatic rps_gate_s rps_decode(input rps_cv_e st);
    rps_gate_s g;
    g = '0;
    case (st)
      CV_OFF: g.ls = 1'b1;
      CV_SOFT, CV_PWM: g.pwm_run = 1'b1;
      CV_SLEEP: g.pfm = 1'b1;
      CV_HS: begin
        g.hs = 1'b1;
        g.pfm = 1'b1;
      end
      CV_LS: begin
        g.ls = 1'b1;
        g.pfm = 1'b1;
      end
      default: g = '0;
    endcase
    return g;
  endfunction
endpackage

/* File: verification/rps_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_host (
  // Clock
  input wire logic clock,
  // Pins toward the device
  output logic trig,
  output logic [3:0] en,
  output logic sup
);
  initial begin
    trig = 1'b0;
    en = 4'h0;
    sup = 1'b0;
  end
  // Pins change just after an edge; converters stay off while supply is low
  task automatic drive(input logic t, input logic [3:0] e, input logic s);
    @(posedge clock);
    trig <= t;
    en <= s ? e : 4'h0;
    sup <= s;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TK = 10;
  localparam int DG = 8;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, trig, sup, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] en, reg_on;
  rps_pkg::rps_sense_s [1:0] sense;
  rps_pkg::rps_gate_s [1:0] gate;
  logic [1:0][9:0] ilim_ma;
  logic [3:0][4:0] vsel;
  int fail_count, check_count, n, mx;
  int t[4];
  int q0[$];
  int q1[$];
  int half[6] = '{2, 3, 4, 6, 12, 22};
  int offt[4] = '{3, 4, 6, 12};
  int code[4] = '{1, 2, 3, 4};
  int ss0[3] = '{180, 300, 720};
  int ss1[3] = '{161, 300, 536};
  logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
  logic [31:0] rv[7] = '{32'h801, 32'h1001, 32'h801, 32'h1001, 32'h8d1, 32'h61883, 32'h0};
  logic [6:0] sv[4] = '{7'h50, 7'h52, 7'h49, 7'h44};
  logic [3:0] gv[4] = '{4'h9, 4'h5, 4'h1, 4'h2};
  logic [15:0] lf = 16'hfdec;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  rps_sequencer #(.TICK_CYCLES(TK), .DEGLITCH_CYCLES(DG), .OFF_DLY(20'h61883)) dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seq_trigger_pin(trig), .buck_one_enable_pin(en[0]), .buck_two_enable_pin(en[1]),
    .linear_one_enable_pin(en[2]), .linear_two_enable_pin(en[3]), .supply_ok(sup),
    .sense(sense), .gate(gate), .ilim_ma(ilim_ma), .reg_on(reg_on), .vsel(vsel));
  rps_host host (.clock(clock), .trig(trig), .en(en), .sup(sup));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_t(input int k, input int tk);
    int e;
    e = DG + 3 + tk * TK;
    check_count++;
    if (t[k] < e - TK - 2 || t[k] > e + 6) begin
      fail_count++;
      $display("FAIL seq_time %0d exp %0d got %0d", k, e, t[k]);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("FAIL apb_ready exp 1 got %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_g(input int k, input logic [3:0] v);
    n = 0;
    while (gate[k] !== v && n < 600) begin
      @(posedge clock);
      n++;
    end
  endtask
  // First cycle at which each regulator shows the given level
  task automatic meas(input logic dir);
    for (int k = 0; k < 4; k++) t[k] = -1;
    for (int c = 1; c <= 400; c++) begin
      @(posedge clock);
      for (int k = 0; k < 4; k++) if (t[k] < 0 && reg_on[k] === dir) t[k] = c;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sense = '0;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("reg_on", 4'h0, reg_on);
    chk("gate", 8'h44, gate);
    chk("vsel", {5'h10, 5'h08, 5'h10, 5'h08}, vsel);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("prdata", rv[i], rd);
      chk("pslverr", i == 6, er);
    end
    host.drive(1'b0, 4'h3, 1'b1);
    for (int c = 0; c < 9500; c++) begin
      @(posedge clock);
      if (ilim_ma[0] != 0 && (q0.size() == 0 || q0[$] != ilim_ma[0])) q0.push_back(ilim_ma[0]);
      if (ilim_ma[1] != 0 && (q1.size() == 0 || q1[$] != ilim_ma[1])) q1.push_back(ilim_ma[1]);
      if (q0.size() > 0 && q1.size() > 0 && ilim_ma === '0) break;
    end
    chk("reg_on", 4'h3, reg_on);
    chk("steps", 6, q0.size() + q1.size());
    for (int k = 0; k < 3; k++) begin
      chk("ilim0", ss0[k], q0[k]);
      chk("ilim1", ss1[k], q1[k]);
    end
    sense[0] <= rps_pkg::rps_sense_s'(7'h40);
    wait_g(0, 4'h1);
    chk("pfm_delay", 1, n >= 352 && n < 420);
    for (int i = 0; i < 4; i++) begin
      sense[0] <= rps_pkg::rps_sense_s'(sv[i]);
      wait_g(0, gv[i]);
      chk("gate0", gv[i], gate[0]);
    end
    sense[0] <= rps_pkg::rps_sense_s'(7'h40);
    apb(1'b1, 8'h00, 32'h803);
    repeat (450) @(posedge clock);
    chk("gate0", 4'h2, gate[0]);
    sense[0] <= '0;
    apb(1'b1, 8'h00, 32'h800);
    repeat (8) @(posedge clock);
    chk("reg_on", 4'h2, reg_on);
    chk("gate0", 4'h4, gate[0]);
    apb(1'b1, 8'h00, 32'h801);
    host.drive(1'b0, 4'h0, 1'b1);
    host.drive(1'b1, 4'h0, 1'b1);
    repeat (3) @(posedge clock);
    host.drive(1'b0, 4'h0, 1'b1);
    repeat (300) @(posedge clock);
    chk("reg_on", 4'h0, reg_on);
    host.drive(1'b1, 4'h0, 1'b1);
    meas(1'b1);
    for (int k = 0; k < 4; k++) chk_t(k, half[code[k]]);
    host.drive(1'b1, 4'hf, 1'b1);
    host.drive(1'b1, 4'h0, 1'b1);
    repeat (4) @(posedge clock);
    chk("reg_on", 4'hf, reg_on);
    host.drive(1'b0, 4'h0, 1'b1);
    meas(1'b0);
    for (int k = 0; k < 4; k++) chk_t(k, offt[k]);
    apb(1'b1, 8'h00, 32'h0);
    mx = 0;
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      code[k] = lf % 6;
      if (half[code[k]] > mx) mx = half[code[k]];
    end
    apb(1'b1, 8'h10, 32'(code[0] | code[1] << 3 | code[2] << 6 | code[3] << 9));
    host.drive(1'b1, 4'h0, 1'b1);
    meas(1'b1);
    chk_t(0, mx);
    for (int k = 1; k < 4; k++) chk_t(k, half[code[k]]);
    apb(1'b0, 8'h00, 32'h0);
    chk("first_converter_ctrl", 32'h801, rd);
    host.drive(1'b0, 4'h0, 1'b1);
    apb(1'b1, 8'h10, 32'hb6d);
    repeat (400) @(posedge clock);
    host.drive(1'b1, 4'h0, 1'b1);
    repeat (30) @(posedge clock);
    host.drive(1'b0, 4'h0, 1'b1);
    meas(1'b1);
    chk("abort", 4'h0, {t[3] > 0, t[2] > 0, t[1] > 0, t[0] > 0});
    report_and_stop;
  end
endmodule
`default_nettype wire
